// [safety_io_diagnostic_manager.sv]
// Diagnostic event latching, channel safe-state control and indicator drive
// Summary of operation
// - Cross-circuit codes per input, skipping nibble 4-7
// - Cross-circuit forces input safe until acknowledged
// - Watchdog test fail: outputs safe, red LEDs
// - Symmetry violation blocks pair only with lock
// - Input hardware fault locks until self-test passes
// - Reference fault holds all inputs until self-test
// - Implausible pair held until both inputs safe
// - Test pulse overload: output off, red LED
// - Undervoltage blinks supply LED at 1 Hz
// - Critical temperature warns; further rise means failure
`timescale 1ns/1ns
`include "diag_map.svh"
module safety_io_diagnostic_manager
  import diag_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES = `CLK_HZ / (2 * `BLINK_HZ),
  parameter longint RESTART_GAP_CYCLES = 64'(`RESTART_GAP_S) * 64'(`CLK_HZ)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic safe_input_0,
  input wire logic safe_input_1,
  input wire logic safe_input_2,
  input wire logic safe_input_3,
  input wire logic safe_input_4,
  input wire logic safe_input_5,
  input wire logic safe_input_6,
  input wire logic safe_input_7,
  input wire logic [7:0] cross_fault,
  input wire logic [7:0] input_hw_fault,
  input wire logic ref_source_fault,
  input wire logic [3:0] watchdog_test_fail,
  input wire logic [3:0] symmetry_fault,
  input wire logic [3:0] implausible_change,
  input wire logic [1:0] test_pulse_overload,
  input wire logic [1:0] supply_undervoltage,
  input wire logic temp_critical,
  input wire logic temp_shutdown,
  input wire logic selftest_pass,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic [7:0] input_value,
  output logic main_output_en,
  output logic zone_one_output,
  output logic zone_two_output,
  output logic zone_three_output,
  output logic [3:0] output_red_led,
  output logic test_pulse_output_a,
  output logic test_pulse_output_b,
  output logic test_pulse_red_led_a,
  output logic test_pulse_red_led_b,
  output logic input_logic_supply_led,
  output logic output_load_supply_led,
  output logic failure_state,
  output logic [11:0] diag_code,
  output logic diag_valid,
  output logic irq
);

  // =============================================
  // Pin synchroniser: every monitor and input pin passes two flops
  localparam int NPIN = 44;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_s;
  assign pin_raw = {selftest_pass, temp_shutdown, temp_critical, supply_undervoltage, test_pulse_overload,
                    implausible_change, symmetry_fault, watchdog_test_fail, ref_source_fault, input_hw_fault,
                    cross_fault, safe_input_7, safe_input_6, safe_input_5, safe_input_4, safe_input_3,
                    safe_input_2, safe_input_1, safe_input_0};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_s <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_s <= pin_meta;
    end
  end

  logic [7:0] in_s, xc_s, hw_s;
  logic [3:0] wd_s, sym_s, impl_s;
  logic [1:0] tp_s, uv_s;
  logic ref_s, tcrit_s, tshut_s, stpass_s;
  assign in_s = pin_s[7:0];
  assign xc_s = pin_s[15:8];
  assign hw_s = pin_s[23:16];
  assign ref_s = pin_s[24];
  assign wd_s = pin_s[28:25];
  assign sym_s = pin_s[32:29];
  assign impl_s = pin_s[36:33];
  assign tp_s = pin_s[38:37];
  assign uv_s = pin_s[40:39];
  assign tcrit_s = pin_s[41];
  assign tshut_s = pin_s[42];
  assign stpass_s = pin_s[43];

  // =============================================
  // Software registers
  logic [11:0] ctrl;
  logic [7:0] tp_select;
  logic [3:0] out_request;
  logic [`IRQ_NUM-1:0] irq_stat, irq_mask;
  logic ack_wr;
  logic [11:0] ack_code;
  logic sym_lock;
  logic [3:0] two_ch, antiv;
  assign sym_lock = ctrl[`CTRL_SYMLOCK];
  assign two_ch = ctrl[`CTRL_TWOCH_LSB +: 4];
  assign antiv = ctrl[`CTRL_ANTIV_LSB +: 4];
  assign ack_wr = wr_en && (addr == `OFF_ACK);
  assign ack_code = wr_data[11:0];

  // Configuration writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      tp_select <= 8'h00;
      out_request <= 4'h0;
      irq_mask <= '0;
    end else if (wr_en) begin
      case (addr)
        `OFF_CTRL: ctrl <= wr_data[11:0];
        `OFF_TPSEL: tp_select <= wr_data[7:0];
        `OFF_OUTREQ: out_request <= wr_data[3:0];
        `OFF_IRQMASK: irq_mask <= wr_data[`IRQ_NUM-1:0];
        default: ;
      endcase
    end
  end

  // =============================================
  // Event code and interrupt class of each latch entry
  function automatic diag_code_t ev_code(input int idx);
    int ch;
    ch = 0;
    if (idx < `EV_HW) begin
      ch = (idx < 4) ? idx : idx + `HI_GROUP_SKIP;
      ev_code = `CODE_XC + 12'(ch);
    end else if (idx < `EV_REF) begin
      ch = (idx - `EV_HW < 4) ? idx - `EV_HW : idx - `EV_HW + `HI_GROUP_SKIP;
      ev_code = `CODE_HWIN + 12'(ch);
    end else if (idx == `EV_REF) begin
      ev_code = `CODE_REF;
    end else if (idx < `EV_SYM) begin
      ev_code = `CODE_WDOG + 12'(idx - `EV_WD);
    end else if (idx < `EV_IMPL) begin
      ev_code = `CODE_SYM + 12'(idx - `EV_SYM);
    end else if (idx < `EV_TPS) begin
      ev_code = `CODE_IMPL + 12'(idx - `EV_IMPL);
    end else if (idx < `EV_UV) begin
      ev_code = `CODE_TPS + 12'((idx - `EV_TPS) * `TP_CODE_STEP);
    end else if (idx < `EV_TEMP) begin
      ev_code = `CODE_UV + 12'(idx - `EV_UV);
    end else if (idx == `EV_TEMP) begin
      ev_code = `CODE_TEMP;
    end else begin
      ev_code = `CODE_GAP;
    end
  endfunction : ev_code

  function automatic int ev_class(input int idx);
    if (idx < `EV_HW) ev_class = 0;
    else if (idx < `EV_REF) ev_class = 1;
    else if (idx == `EV_REF) ev_class = 2;
    else if (idx < `EV_SYM) ev_class = 3;
    else if (idx < `EV_IMPL) ev_class = 4;
    else if (idx < `EV_TPS) ev_class = 5;
    else if (idx < `EV_UV) ev_class = 6;
    else if (idx < `EV_TEMP) ev_class = 7;
    else if (idx == `EV_TEMP) ev_class = 8;
    else ev_class = 9;
  endfunction : ev_class

  // =============================================
  // Event latches
  logic [`EV_NUM-1:0] ev_cond, ev_lat, ack_hit, ev_set, keep_mask;
  logic gap_violation;
  assign ev_cond = {gap_violation, tcrit_s, uv_s, tp_s, impl_s & two_ch, sym_s & two_ch, wd_s, ref_s, hw_s, xc_s};
  assign ev_set = ev_cond & ~ev_lat;
  assign keep_mask = ev_lat & ~ack_hit;

  // One latch per code; a persisting condition beats the acknowledge
  for (genvar g = 0; g < `EV_NUM; g++) begin : g_event
    assign ack_hit[g] = ack_wr && (ack_code == ev_code(g));
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        ev_lat[g] <= 1'b0;
      end else if (ev_cond[g]) begin
        ev_lat[g] <= 1'b1;
      end else if (ack_hit[g]) begin
        ev_lat[g] <= 1'b0;
      end
    end
  end

  logic [7:0] xc_lat;
  logic [3:0] wd_lat, sym_lat;
  logic [1:0] tp_lat;
  logic wd_any;
  assign xc_lat = ev_lat[`EV_XC +: 8];
  assign wd_lat = ev_lat[`EV_WD +: 4];
  assign sym_lat = ev_lat[`EV_SYM +: 4];
  assign tp_lat = ev_lat[`EV_TPS +: 2];
  assign wd_any = |wd_lat;

  // =============================================
  // Locks that only a clean power-up self-test lifts
  logic [7:0] hw_lock;
  logic ref_lock;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hw_lock <= 8'h00;
      ref_lock <= 1'b0;
    end else begin
      hw_lock <= hw_s | (hw_lock & ~{8{stpass_s}});
      ref_lock <= ref_s | (ref_lock & ~stpass_s);
    end
  end

  // Further temperature rise is terminal until reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      failure_state <= 1'b0;
    end else if (tshut_s) begin
      failure_state <= 1'b1;
    end
  end

  // =============================================
  // Two-channel pair evaluation
  logic [3:0] pair_err, b_active, pair_val, pair_block;

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      b_active[p] = antiv[p] ? ~in_s[p+4] : in_s[p+4];
      pair_val[p] = in_s[p] & b_active[p];
      pair_block[p] = pair_err[p] | (sym_lat[p] & sym_lock);
    end
  end

  // Held until both inputs of the pair sit in their safe state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pair_err <= 4'h0;
    end else begin
      pair_err <= (impl_s & two_ch) | (pair_err & (in_s[3:0] | b_active));
    end
  end

  // =============================================
  // Input gating: every pending cause keeps a channel in its safe value
  logic [7:0] in_block, next_input_value;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      in_block[i] = xc_lat[i] | hw_lock[i] | ref_lock | failure_state
                    | tp_lat[tp_select[i]]
                    | (two_ch[i % 4] & pair_block[i % 4]);
      if (in_block[i]) next_input_value[i] = 1'b0;
      else if (two_ch[i % 4]) next_input_value[i] = pair_val[i % 4];
      else next_input_value[i] = in_s[i];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_value <= 8'h00;
    end else begin
      input_value <= next_input_value;
    end
  end

  // =============================================
  // Restart spacing: an output restart starts the gap timer
  gap_state_t gap_state;
  logic [63:0] gap_cnt;
  logic wd_any_q, restart_pulse;
  assign restart_pulse = wd_any_q & ~wd_any;
  assign gap_violation = restart_pulse && (gap_state == GAP_RUN);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wd_any_q <= 1'b0;
    end else begin
      wd_any_q <= wd_any;
    end
  end

  // A too-early restart does not extend the running gap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_state <= GAP_IDLE;
      gap_cnt <= 64'h0;
    end else begin
      case (gap_state)
        GAP_IDLE: begin
          if (restart_pulse) begin
            gap_state <= GAP_RUN;
            gap_cnt <= 64'h0;
          end
        end
        GAP_RUN: begin
          if (gap_cnt >= RESTART_GAP_CYCLES - 64'h1) gap_state <= GAP_IDLE;
          else gap_cnt <= gap_cnt + 64'h1;
        end
        default: gap_state <= GAP_IDLE;
      endcase
    end
  end

  // =============================================
  // Output, test-pulse and LED drive
  logic blink_tick, blink_phase, out_block;
  // The violation pulse itself blocks too, so an early restart never glitches the outputs on
  assign out_block = wd_any | gap_violation | ev_lat[`EV_GAP] | failure_state;

  tick_divider #(
    .DIV(BLINK_HALF_CYCLES)
  ) u_blink (
    .core_clk(core_clk),
    .rst(rst),
    .tick(blink_tick)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blink_phase <= 1'b0;
    end else if (blink_tick) begin
      blink_phase <= ~blink_phase;
    end
  end

  // Outputs restart by themselves once the last blocking cause is acknowledged
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_output_en <= 1'b0;
      zone_one_output <= 1'b0;
      zone_two_output <= 1'b0;
      zone_three_output <= 1'b0;
      output_red_led <= 4'h0;
    end else begin
      main_output_en <= out_request[0] & ~out_block;
      zone_one_output <= out_request[1] & ~out_block;
      zone_two_output <= out_request[2] & ~out_block;
      zone_three_output <= out_request[3] & ~out_block;
      output_red_led <= {4{wd_any}};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      test_pulse_output_a <= 1'b0;
      test_pulse_output_b <= 1'b0;
      test_pulse_red_led_a <= 1'b0;
      test_pulse_red_led_b <= 1'b0;
    end else begin
      test_pulse_output_a <= ~tp_lat[0] & ~failure_state;
      test_pulse_output_b <= ~tp_lat[1] & ~failure_state;
      test_pulse_red_led_a <= tp_lat[0];
      test_pulse_red_led_b <= tp_lat[1];
    end
  end

  // Steady on when healthy; blink only while undervoltage is present
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_logic_supply_led <= 1'b0;
      output_load_supply_led <= 1'b0;
    end else begin
      input_logic_supply_led <= uv_s[0] ? blink_phase : 1'b1;
      output_load_supply_led <= uv_s[1] ? blink_phase : 1'b1;
    end
  end

  // =============================================
  // Reported code: lowest latched entry wins
  diag_code_t next_code;
  always_comb begin
    next_code = 12'h000;
    for (int i = `EV_NUM - 1; i >= 0; i--) begin
      if (ev_lat[i]) next_code = ev_code(i);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      diag_code <= 12'h000;
      diag_valid <= 1'b0;
    end else begin
      diag_code <= next_code;
      diag_valid <= |ev_lat;
    end
  end

  // =============================================
  // Interrupts: new events set class bits, write one to clear, set wins
  logic [`IRQ_NUM-1:0] class_set;
  always_comb begin
    class_set = '0;
    for (int i = 0; i < `EV_NUM; i++) begin
      if (ev_set[i]) class_set[ev_class(i)] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && addr == `OFF_IRQSTAT) irq_stat <= class_set | (irq_stat & ~wr_data[`IRQ_NUM-1:0]);
      else irq_stat <= class_set | irq_stat;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // =============================================
  // Read port: data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        `OFF_CTRL: rd_data <= {20'h0, ctrl};
        `OFF_TPSEL: rd_data <= {24'h0, tp_select};
        `OFF_OUTREQ: rd_data <= {28'h0, out_request};
        `OFF_DIAG: rd_data <= {|ev_lat, 19'h0, next_code};
        `OFF_EVLO: rd_data <= ev_lat[31:0];
        `OFF_EVHI: rd_data <= {19'h0, failure_state, ref_lock, hw_lock, ev_lat[`EV_NUM-1:32]};
        `OFF_IRQSTAT: rd_data <= {22'h0, irq_stat};
        `OFF_IRQMASK: rd_data <= {22'h0, irq_mask};
        `OFF_INVAL: rd_data <= {24'h0, input_value};
        default: rd_data <= 32'h0000_0000;
      endcase
    end else begin
      rd_data <= 32'h0000_0000;
    end
  end

  // =============================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_xc_code_seven: assert property (ev_lat == 35'h0_0000_0080 |=> diag_code == (`CODE_XC + 12'h00B))
    else $error("cross-circuit code for input seven wrong");
  a_xc_input_safe: assert property (xc_lat[3] |=> !input_value[3])
    else $error("cross-circuit input not held safe");
  a_wdog_outputs_off: assert property (wd_any |=> !main_output_en && !zone_three_output && output_red_led == 4'hF)
    else $error("watchdog test fail did not force outputs safe");
  a_sym_lock_blocks: assert property (sym_lat[1] && sym_lock && two_ch[1] |=> !input_value[1] && !input_value[5])
    else $error("symmetry lock did not block pair");
  a_hw_lock_holds: assert property (hw_lock[2] && !stpass_s && !ack_wr |=> hw_lock[2] && !input_value[2])
    else $error("hardware lock released without self-test");
  a_ref_all_safe: assert property (ref_lock |=> input_value == 8'h00)
    else $error("reference fault did not hold inputs safe");
  a_pair_err_hold: assert property (pair_err[0] && (in_s[0] || b_active[0]) |=> pair_err[0])
    else $error("implausible pair released early");
  a_tp_overload_off: assert property (tp_lat[0] |=> !test_pulse_output_a && test_pulse_red_led_a)
    else $error("test pulse output not switched off");
  a_uv_led_blink: assert property (uv_s[0] |=> input_logic_supply_led == $past(blink_phase))
    else $error("supply led not blinking under undervoltage");
  a_uv_led_steady: assert property (!uv_s[1] |=> output_load_supply_led)
    else $error("supply led not steady after undervoltage");
  a_failure_sticky: assert property (tshut_s |=> failure_state ##1 failure_state)
    else $error("failure state not held");
  a_gap_violation: assert property (restart_pulse && gap_state == GAP_RUN |=> ev_lat[`EV_GAP] && !main_output_en)
    else $error("early restart not flagged");
  a_latch_kept: assert property (1'b1 |=> (ev_lat & $past(keep_mask)) == $past(keep_mask))
    else $error("event dropped without acknowledge");

  c_xc_ack: cover property (xc_lat[0] ##1 ack_hit[0] ##1 !xc_lat[0]);
  c_gap_hit: cover property (gap_violation);
  c_failure: cover property ($rose(failure_state));
  c_uv_blink: cover property (uv_s[0] && blink_tick);

endmodule : safety_io_diagnostic_manager

// [diag_map.svh]
// Register offsets, event codes, field positions and timing figures of the diagnostic manager
`ifndef DIAG_MAP_SVH
`define DIAG_MAP_SVH

// =============================================
// Timing
`define CLK_HZ 50000000
`define BLINK_HZ 1
`define RESTART_GAP_S 30

// =============================================
// Register offsets (byte addresses)
`define OFF_CTRL 8'h00
`define OFF_TPSEL 8'h04
`define OFF_OUTREQ 8'h08
`define OFF_ACK 8'h0C
`define OFF_DIAG 8'h10
`define OFF_EVLO 8'h14
`define OFF_EVHI 8'h18
`define OFF_IRQSTAT 8'h1C
`define OFF_IRQMASK 8'h20
`define OFF_INVAL 8'h24

// =============================================
// Control register fields and reset values
`define CTRL_SYMLOCK 0
`define CTRL_TWOCH_LSB 4
`define CTRL_ANTIV_LSB 8
`define CTRL_RESET 12'h001
`define DIAG_VALID_BIT 31

// =============================================
// Diagnostic code bases
`define CODE_XC 12'h120
`define CODE_SYM 12'h130
`define CODE_HWIN 12'h140
`define CODE_REF 12'h170
`define CODE_IMPL 12'h180
`define CODE_TPS 12'h1E0
`define CODE_UV 12'h1F0
`define CODE_TEMP 12'h1F2
`define CODE_GAP 12'h1F5
`define CODE_WDOG 12'h2E0
`define HI_GROUP_SKIP 4
`define TP_CODE_STEP 8

// =============================================
// Event latch indices and interrupt classes
`define EV_XC 0
`define EV_HW 8
`define EV_REF 16
`define EV_WD 17
`define EV_SYM 21
`define EV_IMPL 25
`define EV_TPS 29
`define EV_UV 31
`define EV_TEMP 33
`define EV_GAP 34
`define EV_NUM 35
`define IRQ_NUM 10

`endif

// [diag_pkg.sv]
// Types shared by the diagnostic manager files
package diag_pkg;

  // =============================================
  // Restart spacing supervisor states
  typedef enum logic [1:0] {
    GAP_IDLE = 2'b01,
    GAP_RUN = 2'b10
  } gap_state_t;

  typedef logic [11:0] diag_code_t;

endpackage : diag_pkg

// [tick_divider.sv]
// Free running divider that emits a one-cycle enable every DIV clocks
`timescale 1ns/1ns
module tick_divider #(
  parameter int DIV = 25000000
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic tick
);

  // =============================================
  // Counter
  logic [31:0] count;

  // Wraps at DIV-1; tick is registered so it never glitches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (count == 32'(DIV - 1)) begin
      count <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

endmodule : tick_divider

// [ack_partner.sv]
// Controller model: register port master that spaces restart acknowledgements
`timescale 1ns/1ns
module ack_partner #(
  parameter int GAP = 60
) (
  input wire logic core_clk,
  input wire logic [31:0] rd_data,
  output logic [7:0] addr,
  output logic [31:0] wr_data,
  output logic wr_en,
  output logic rd_en
);
  int cyc_now = 0;
  int last_ack = -1000;
  logic hurry = 1'b0;
  // =============================================
  // Cycle count for acknowledgement spacing
  always @(posedge core_clk) cyc_now <= cyc_now + 1;
  initial {addr, wr_data, wr_en, rd_en} = '0;
  // One-cycle write strobe, set just after a rising edge
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : write
  // Read data stand only in the cycle after the strobe
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(posedge core_clk);
    d = rd_data;
  endtask : read
  // Acknowledge by code; hurry breaks the spacing on purpose
  task automatic ack(input logic [11:0] code);
    while (!hurry && cyc_now - last_ack < GAP) @(posedge core_clk);
    write(8'h0C, {20'h0, code});
    last_ack = cyc_now;
  endtask : ack
endmodule : ack_partner

// [tb.sv]
// Self-checking bench for the diagnostic manager
`timescale 1ns/1ns
module tb;
  import diag_pkg::*;
  logic core_clk, rst, safe_input_0, safe_input_1, safe_input_2, safe_input_3;
  logic safe_input_4, safe_input_5, safe_input_6, safe_input_7;
  logic [7:0] cross_fault, input_hw_fault, addr, input_value;
  logic [3:0] watchdog_test_fail, symmetry_fault, implausible_change, output_red_led;
  logic [1:0] test_pulse_overload, supply_undervoltage;
  logic ref_source_fault, temp_critical, temp_shutdown, selftest_pass, wr_en, rd_en;
  logic [31:0] wr_data, rd_data, rdv;
  logic main_output_en, zone_one_output, zone_two_output, zone_three_output;
  logic test_pulse_output_a, test_pulse_output_b, test_pulse_red_led_a, test_pulse_red_led_b;
  logic input_logic_supply_led, output_load_supply_led, failure_state, diag_valid, irq, led;
  diag_code_t diag_code;
  int n_fail, checked, seed, k, flips;
  safety_io_diagnostic_manager #(.BLINK_HALF_CYCLES(4), .RESTART_GAP_CYCLES(50)) u_safety_io_diagnostic_manager (.*);
  ack_partner #(.GAP(60)) u_ack_partner (.core_clk(core_clk), .rd_data(rd_data), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en));
  // =============================================
  // Clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Compare tasks count every check
  task automatic chk_w(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk_w
  task automatic chk_b(input string what, input logic e, input logic g);
    chk_w(what, {31'h0, e}, {31'h0, g});
  endtask : chk_b
  task automatic set_in(input logic [7:0] v);
    {safe_input_7, safe_input_6, safe_input_5, safe_input_4} <= v[7:4];
    {safe_input_3, safe_input_2, safe_input_1, safe_input_0} <= v[3:0];
  endtask : set_in
  // Model: inputs four to seven skip four code values
  function automatic int in_code(input int base, input int i);
    return base + (i < 4 ? i : i + 4);
  endfunction : in_code
  // Wait for the monitor to drop out of the synchroniser, then acknowledge
  task automatic clr(input int code);
    cyc(4);
    u_ack_partner.ack(12'(code));
    cyc(5);
  endtask : clr
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(20000);
    n_fail++;
    report_and_stop();
  end
  // =============================================
  // Main sequence
  initial begin
    seed = 32'h8207;
    rst = 1'b1;
    {cross_fault, input_hw_fault, watchdog_test_fail, symmetry_fault, implausible_change} = '0;
    {test_pulse_overload, supply_undervoltage, ref_source_fault, temp_critical} = '0;
    {temp_shutdown, selftest_pass} = '0;
    set_in(8'hFF);
    cyc(5);
    rst <= 1'b0;
    cyc(6);
    chk_b("valid", 1'b0, diag_valid);
    u_ack_partner.write(8'h20, 32'h1);
    for (int i = 0; i < 8; i++) begin
      cross_fault <= 8'h01 << i;
      cyc(6);
      chk_w("cross", in_code(288, i), diag_code);
      chk_b("held", 1'b0, input_value[i]);
      chk_b("irq", 1'b1, irq);
      cross_fault <= 8'h00;
      cyc(8);
      chk_b("latched", 1'b1, diag_valid);
      clr(in_code(288, i));
      chk_b("free", 1'b1, input_value[i]);
    end
    u_ack_partner.write(8'h1C, 32'h3FF);
    u_ack_partner.write(8'h20, 32'h0);
    u_ack_partner.read(8'h3C, rdv);
    chk_w("unmapped", 32'h0, rdv);
    $display("test cross done");
    k = $unsigned($random(seed)) % 8;
    input_hw_fault <= 8'h01 << k;
    ref_source_fault <= 1'b1;
    cyc(6);
    chk_w("hw", in_code(320, k), diag_code);
    chk_b("irq", 1'b0, irq);
    {input_hw_fault, ref_source_fault} <= '0;
    clr(in_code(320, k));
    chk_w("ref", 368, diag_code);
    chk_w("all safe", 8'h00, input_value);
    clr(368);
    chk_b("valid", 1'b0, diag_valid);
    chk_b("hw lock", 1'b0, input_value[k]);
    selftest_pass <= 1'b1;
    cyc(6);
    chk_w("restart", 8'hFF, input_value);
    selftest_pass <= 1'b0;
    $display("test locks done");
    u_ack_partner.write(8'h08, 32'hF);
    for (int i = 0; i < 5; i++) begin
      u_ack_partner.hurry = (i == 4);
      watchdog_test_fail <= 4'h1 << (i % 4);
      cyc(6);
      chk_w("wdog", 736 + i % 4, diag_code);
      chk_w("red", 4'hF, output_red_led);
      chk_w("outs", 4'h0, {zone_three_output, zone_two_output, zone_one_output, main_output_en});
      watchdog_test_fail <= 4'h0;
      clr(736 + i % 4);
      chk_w("red", 4'h0, output_red_led);
    end
    chk_w("gap", 501, diag_code);
    chk_b("main", 1'b0, main_output_en);
    clr(501);
    chk_w("outs", 4'hF, {zone_three_output, zone_two_output, zone_one_output, main_output_en});
    $display("test watchdog done");
    for (int j = 0; j < 2; j++) begin
      test_pulse_overload <= 2'b01 << j;
      supply_undervoltage <= 2'b01 << j;
      cyc(6);
      chk_w("tp", j ? 4'b1001 : 4'b0110, {test_pulse_output_a, test_pulse_output_b,
        test_pulse_red_led_a, test_pulse_red_led_b});
      flips = 0;
      for (int c = 0; c < 10; c++) begin
        led = j ? output_load_supply_led : input_logic_supply_led;
        cyc(1);
        flips += (led !== (j ? output_load_supply_led : input_logic_supply_led));
      end
      chk_b("blink", 1'b1, flips >= 2);
      {test_pulse_overload, supply_undervoltage} <= '0;
      clr(480 + 8 * j);
      chk_w("uv", 496 + j, diag_code);
      chk_b("steady", 1'b1, j ? output_load_supply_led : input_logic_supply_led);
      chk_w("tp", 4'b1100, {test_pulse_output_a, test_pulse_output_b,
        test_pulse_red_led_a, test_pulse_red_led_b});
      clr(496 + j);
    end
    $display("test pulse and supply done");
    u_ack_partner.write(8'h00, 32'h11);
    implausible_change <= 4'h1;
    cyc(6);
    chk_w("impl", 384, diag_code);
    implausible_change <= 4'h0;
    clr(384);
    chk_b("kept", 1'b0, input_value[0]);
    set_in(8'hEE);
    clr(384);
    chk_b("valid", 1'b0, diag_valid);
    set_in(8'hFE);
    cyc(6);
    chk_w("pair", 2'b00, {input_value[4], input_value[0]});
    set_in(8'hFF);
    symmetry_fault <= 4'h1;
    cyc(6);
    chk_w("sym", 304, diag_code);
    chk_b("blocked", 1'b0, input_value[0]);
    symmetry_fault <= 4'h0;
    clr(304);
    chk_b("free", 1'b1, input_value[0]);
    u_ack_partner.write(8'h00, 32'h111);
    set_in(8'hEF);
    cyc(6);
    chk_w("antiv", 2'b11, {input_value[4], input_value[0]});
    $display("test pairs done");
    temp_critical <= 1'b1;
    cyc(6);
    chk_w("temp", 498, diag_code);
    chk_b("fail", 1'b0, failure_state);
    temp_shutdown <= 1'b1;
    cyc(6);
    {temp_critical, temp_shutdown} <= '0;
    clr(498);
    chk_b("fail", 1'b1, failure_state);
    chk_b("valid", 1'b0, diag_valid);
    $display("test temperature done");
    report_and_stop();
  end
endmodule : tb
